//--- hw/hsync_frequency_counter.sv
// Horizontal sync frequency counter: gate mode register, gate sequencer, counter.
// Assumes register file and peripheral strobes come from the CPU core,
// all synchronous to sys_clk; the pin input is already digital.
//
// How it works
// - Count rising sync input edges in a 6-bit counter only while gate is open.
// - Closing the gate freezes the count at the pulses seen while open.
// - Input bias output is driven only in open and timed modes.
// - Counter is read-only at peripheral address 04H via the read op.
// - Two-bit gate mode register lives at register file address 11H.
// - Closed mode: gate shut, counter and tick generator idle, bias off.
// - Reset or clock stop forces the gate mode to closed.
// - Reset or clock stop clears the pulse counter to 00H.
// - Writing open mode opens gate, clears counter, counts with bias on.
// - Counter wraps from its maximum to 00H and keeps counting.
// - Timed mode clears counter and starts within one 62.5 us gate tick.
// - Timed gate stays open exactly 1.69 ms then closes itself.
// - Gate tick generator runs only in timed mode.
// - Writing 0010B to the gate mode register selects timed mode.
// - Shared port bit reads 0 while the pin is used for counting.
// - Gate-open flag is bit 3 of register file address 12H, high when open.
// - In timed mode the flag reads high from mode set until the first tick.
`timescale 1ns/100ps
`include "sync_counter_cfg.svh"

module hsync_frequency_counter #(
    parameter int COUNT_WIDTH = 6,
    parameter int TICK_CYCLES = `GATE_TICK_CYCLES,
    parameter int GATE_CYCLES = `GATE_TIME_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clock_stop,
    input wire logic sync_count_input,
    input wire logic shared_port_bit_in,
    output logic shared_port_bit_read,
    output logic input_bias_on,
    input wire logic regfile_write_op,
    input wire logic regfile_read_op,
    input wire logic [6:0] regfile_addr,
    input wire logic [3:0] regfile_wdata,
    output logic [3:0] regfile_rdata,
    input wire logic peripheral_read_op,
    input wire logic [6:0] peripheral_addr,
    output logic [15:0] transfer_buffer,
    output logic gate_open
);
    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    function automatic logic hit(input logic strobe, input logic [6:0] addr,
                                 input logic [6:0] target);
        hit = strobe && (addr == target);
    endfunction : hit

    wire mode_wr = hit(regfile_write_op, regfile_addr, `REGFILE_ADDR_GATE_MODE);
    wire mode_rd = hit(regfile_read_op, regfile_addr, `REGFILE_ADDR_GATE_MODE);
    wire stat_rd = hit(regfile_read_op, regfile_addr, `REGFILE_ADDR_GATE_STATUS);
    wire cnt_rd = hit(peripheral_read_op, peripheral_addr, `PERIPH_ADDR_SYNC_COUNT);

    // ------------------------------------------------------------------------
    // Gate mode register
    // ------------------------------------------------------------------------
    sync_counter_pkg::gate_mode_t mode_ff;
    sync_counter_pkg::gate_mode_t nxt_mode;
    sync_counter_pkg::gate_state_t state_ff;
    sync_counter_pkg::gate_state_t nxt_state;
    logic [$clog2(GATE_CYCLES+1)-1:0] gate_cnt_ff;
    logic [$clog2(GATE_CYCLES+1)-1:0] nxt_gate_cnt;
    logic [3:0] rdata_ff;
    logic [3:0] nxt_rdata;
    logic [15:0] tbuf_ff;
    logic [15:0] nxt_tbuf;
    logic [COUNT_WIDTH-1:0] count;
    logic tick;
    logic tick_run;
    logic clear_count;
    logic counting;
    logic sync_mode;

    // Only the two low bits store; upper bits of the write are dropped
    assign nxt_mode = clock_stop ? sync_counter_pkg::MODE_CLOSED :
        mode_wr ? sync_counter_pkg::gate_mode_t'(regfile_wdata[1:0]) : mode_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= sync_counter_pkg::MODE_CLOSED;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Gate sequencer
    // ------------------------------------------------------------------------
    // Every mode write restarts the sequence, so rewriting a mode re-arms it
    always_comb begin
        nxt_state = state_ff;
        nxt_gate_cnt = gate_cnt_ff;
        if (clock_stop) begin
            nxt_state = sync_counter_pkg::GATE_IDLE;
        end else if (mode_wr) begin
            unique case (regfile_wdata[1:0])
                `GATE_MODE_OPEN: nxt_state = sync_counter_pkg::GATE_RUN;
                `GATE_MODE_TIMED: nxt_state = sync_counter_pkg::GATE_WAIT_TICK;
                default: nxt_state = sync_counter_pkg::GATE_IDLE;
            endcase
            nxt_gate_cnt = '0;
        end else begin
            unique case (state_ff)
                sync_counter_pkg::GATE_IDLE: begin
                end
                sync_counter_pkg::GATE_WAIT_TICK: begin
                    if (tick) begin
                        nxt_state = sync_counter_pkg::GATE_RUN;
                    end
                end
                sync_counter_pkg::GATE_RUN: begin
                    if (mode_ff == sync_counter_pkg::MODE_TIMED) begin
                        nxt_gate_cnt = gate_cnt_ff + 1'b1;
                        if (gate_cnt_ff == ($bits(gate_cnt_ff))'(GATE_CYCLES - 1)) begin
                            nxt_state = sync_counter_pkg::GATE_DONE;
                        end
                    end
                end
                sync_counter_pkg::GATE_DONE: begin
                    // Gate stays shut and the count holds until a mode write or clock stop
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= sync_counter_pkg::GATE_IDLE;
            gate_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            gate_cnt_ff <= nxt_gate_cnt;
        end
    end

    assign counting = (state_ff == sync_counter_pkg::GATE_RUN);
    assign gate_open = counting;
    assign sync_mode = (mode_ff == sync_counter_pkg::MODE_OPEN) ||
        (mode_ff == sync_counter_pkg::MODE_TIMED);
    assign input_bias_on = sync_mode;
    assign tick_run = (mode_ff == sync_counter_pkg::MODE_TIMED) && !clock_stop;
    // Clear on entry to a counting mode; a closed-mode write leaves the count alone
    assign clear_count = clock_stop || (mode_wr && (regfile_wdata[1:0] == `GATE_MODE_OPEN ||
        regfile_wdata[1:0] == `GATE_MODE_TIMED));

    // ------------------------------------------------------------------------
    // Gate clock and counter
    // ------------------------------------------------------------------------
    gate_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(tick_run),
        .tick(tick)
    );

    // Counter sees pulses only through the gate; frozen otherwise
    pulse_counter #(
        .WIDTH(COUNT_WIDTH)
    ) u_count (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clear(clear_count),
        .gate_open(counting),
        .pulse_in(sync_count_input),
        .count(count)
    );

    // ------------------------------------------------------------------------
    // Read paths
    // ------------------------------------------------------------------------
    // Flag covers the wait for the first tick as well as the open interval
    wire flag_open = counting || (state_ff == sync_counter_pkg::GATE_WAIT_TICK);
    assign nxt_rdata = mode_rd ? {2'h0, mode_ff} :
        stat_rd ? {flag_open, 3'h0} :
        rdata_ff;
    assign nxt_tbuf = cnt_rd ? {{(16-COUNT_WIDTH){1'b0}}, count} : tbuf_ff;
    // Port bit is masked whenever the pin serves the counter
    assign shared_port_bit_read = shared_port_bit_in && !sync_mode;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 4'h0;
            tbuf_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
            tbuf_ff <= nxt_tbuf;
        end
    end

    assign regfile_rdata = rdata_ff;
    assign transfer_buffer = tbuf_ff;

    // ------------------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------------------
    // Long timing rules are checked against these counters, not delay ranges,
    // since the real gate spans tens of thousands of cycles
    logic [$clog2(TICK_CYCLES+1)-1:0] wait_len_ff;
    logic [$clog2(TICK_CYCLES+1)-1:0] nxt_wait_len;
    logic [$clog2(GATE_CYCLES+1)-1:0] open_len_ff;
    logic [$clog2(GATE_CYCLES+1)-1:0] nxt_open_len;
    wire in_wait = (state_ff == sync_counter_pkg::GATE_WAIT_TICK);
    wire in_done = (state_ff == sync_counter_pkg::GATE_DONE);

    assign nxt_wait_len = in_wait ? wait_len_ff + 1'b1 : '0;
    // Held through the done state so the closing check sees the whole span
    assign nxt_open_len = counting ? open_len_ff + 1'b1 :
        in_done ? open_len_ff : '0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_len_ff <= '0;
            open_len_ff <= '0;
        end else begin
            wait_len_ff <= nxt_wait_len;
            open_len_ff <= nxt_open_len;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_timed_write;
        mode_wr && !clock_stop && regfile_wdata[1:0] == `GATE_MODE_TIMED;
    endsequence

    AST_CLOSED_FREEZE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !gate_open && !clear_count |=> $stable(count))
        else $error("count moved while gate closed");
    AST_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        gate_open && !clear_count && count == '1 && sync_count_input && !u_count.prev_ff
        |=> count == '0)
        else $error("counter did not wrap to zero");
    AST_OPEN_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_wr && !clock_stop && regfile_wdata[1:0] == `GATE_MODE_OPEN
        |=> count == '0 && gate_open && input_bias_on)
        else $error("open mode did not clear and open");
    AST_TIMED_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_timed_write |=> count == '0 && !gate_open)
        else $error("timed mode did not clear counter");
    AST_STOP_CLOSES: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clock_stop |=> mode_ff == sync_counter_pkg::MODE_CLOSED && count == '0 && !gate_open)
        else $error("clock stop did not close gate");
    AST_BIAS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == sync_counter_pkg::MODE_CLOSED |-> !input_bias_on && !tick)
        else $error("bias or tick active in closed mode");
    AST_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stat_rd |=> regfile_rdata[`GATE_OPEN_STATUS_BIT] == $past(flag_open))
        else $error("gate flag read wrong");
    AST_PORT_MASK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sync_mode |-> !shared_port_bit_read)
        else $error("port bit not masked");
    AST_TIMED_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == sync_counter_pkg::GATE_DONE && !clear_count |=> $stable(count))
        else $error("count changed after timed gate");

    sequence s_gate_closes;
        $rose(state_ff == sync_counter_pkg::GATE_DONE);
    endsequence

    AST_START_BOUND: assert property (@(posedge sys_clk) disable iff (!reset_n)
        in_wait |-> wait_len_ff < ($bits(wait_len_ff))'(TICK_CYCLES))
        else $error("timed gate started late");
    AST_GATE_MAX: assert property (@(posedge sys_clk) disable iff (!reset_n)
        counting && mode_ff == sync_counter_pkg::MODE_TIMED
        |-> open_len_ff < ($bits(open_len_ff))'(GATE_CYCLES))
        else $error("timed gate stayed open too long");
    AST_GATE_SPAN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_gate_closes |-> open_len_ff == ($bits(open_len_ff))'(GATE_CYCLES))
        else $error("timed gate closed early");
    AST_TICK_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff != sync_counter_pkg::MODE_TIMED |-> !tick ##1 u_tick.div_ff == '0)
        else $error("gate clock ran outside timed mode");
    AST_WAIT_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
        in_wait && stat_rd |=> regfile_rdata[`GATE_OPEN_STATUS_BIT])
        else $error("flag low while waiting for gate clock");
    AST_COUNT_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cnt_rd |=> transfer_buffer[COUNT_WIDTH-1:0] == $past(count)
        && transfer_buffer[15:COUNT_WIDTH] == '0)
        else $error("counter read returned wrong value");
    AST_MODE_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_wr && !clock_stop |=> mode_ff == $past(regfile_wdata[1:0]))
        else $error("mode write not stored");
    AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        gate_open && !clear_count && sync_count_input && !u_count.prev_ff && count != '1
        |=> count == $past(count) + 1'b1)
        else $error("counter missed a gated edge");
    AST_SPARE_SHUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == sync_counter_pkg::MODE_SPARE |-> !gate_open && !input_bias_on)
        else $error("spare mode opened gate or bias");
endmodule : hsync_frequency_counter

//--- hw/sync_counter_cfg.svh
// Constants of the horizontal sync frequency counter: offsets, fields, resets, timing.
// Assumes a 25 MHz system clock; included by the package users by bare name.
`ifndef SYNC_COUNTER_CFG_SVH
`define SYNC_COUNTER_CFG_SVH

// ----------------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------------
`define PERIPH_ADDR_SYNC_COUNT 7'h04
`define REGFILE_ADDR_GATE_MODE 7'h11
`define REGFILE_ADDR_GATE_STATUS 7'h12

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GATE_OPEN_STATUS_BIT 3
`define SYNC_COUNT_RESET 6'h00
`define GATE_MODE_RESET 2'h0
`define GATE_MODE_CLOSED 2'h0
`define GATE_MODE_OPEN 2'h1
`define GATE_MODE_TIMED 2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define GATE_TICK_PERIOD_NS 62500
`define GATE_TIME_NS 1690000
// Longest start delay rounds down; gate time is an exact whole count
`define GATE_TICK_CYCLES (`GATE_TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define GATE_TIME_CYCLES (`GATE_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- hw/sync_counter_pkg.sv
// Types shared by the horizontal sync frequency counter files.
// Assumes nothing beyond a SystemVerilog compiler.
package sync_counter_pkg;

    typedef enum logic [1:0] {
        MODE_CLOSED,
        MODE_OPEN,
        MODE_TIMED,
        MODE_SPARE
    } gate_mode_t;

    typedef enum logic [1:0] {
        GATE_IDLE,
        GATE_WAIT_TICK,
        GATE_RUN,
        GATE_DONE
    } gate_state_t;

endpackage : sync_counter_pkg

//--- hw/gate_tick_gen.sv
// Gate clock generator: a free divider that emits one-cycle ticks while enabled.
// Assumes the enable drops whenever the timed mode is left, so it restarts at zero.
`timescale 1ns/100ps
`include "sync_counter_cfg.svh"

module gate_tick_gen #(
    parameter int TICK_CYCLES = `GATE_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    logic [$clog2(TICK_CYCLES)-1:0] div_ff;
    logic [$clog2(TICK_CYCLES)-1:0] nxt_div;
    logic wrap;

    assign wrap = (div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
    assign nxt_div = (!run || wrap) ? '0 : div_ff + 1'b1;
    assign tick = run && wrap;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end
endmodule : gate_tick_gen

//--- hw/pulse_counter.sv
// Six-bit gated pulse counter with synchronous clear and rising-edge counting.
// Assumes the conditioned input is already synchronous to sys_clk.
`timescale 1ns/100ps
`include "sync_counter_cfg.svh"

module pulse_counter #(
    parameter int WIDTH = 6
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic gate_open,
    input wire logic pulse_in,
    output logic [WIDTH-1:0] count
);
    logic prev_ff;
    logic edge_seen;
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;

    assign edge_seen = pulse_in && !prev_ff;
    // Plain binary add wraps to zero past the top value
    assign nxt_count = clear ? '0 :
        (gate_open && edge_seen) ? count_ff + 1'b1 : count_ff;
    assign count = count_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_ff <= 1'b0;
            count_ff <= '0;
        end else begin
            prev_ff <= pulse_in;
            count_ff <= nxt_count;
        end
    end
endmodule : pulse_counter

//--- dv/sync_source.sv
// Partner model: horizontal sync source feeding the counter input.
// Assumes a request pulse on go with the pulse count on n; line rests low.
`timescale 1ns/100ps

module sync_source (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic [7:0] n,
    output logic sync_line,
    output logic busy
);
    logic [7:0] left_ff;
    logic [1:0] ph_ff;

    // Two cycles high, two low: each pulse gives exactly one rising edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            left_ff <= 8'h00;
            ph_ff <= 2'h0;
        end else if (go) begin
            left_ff <= n;
            ph_ff <= 2'h0;
        end else if (left_ff != 8'h00) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3) begin
                left_ff <= left_ff - 8'h01;
            end
        end
    end

    assign sync_line = (left_ff != 8'h00) && !ph_ff[1];
    assign busy = (left_ff != 8'h00);
endmodule : sync_source

//--- dv/tb_top.sv
// Testbench for the horizontal sync frequency counter.
// Assumes the design files compile first; gate counts are shortened.
`timescale 1ns/100ps

module tb_top;
    localparam int TICK = 4;
    localparam int GATE = 20;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clock_stop = 1'b0;
    logic sync_line;
    logic busy;
    logic go = 1'b0;
    logic [7:0] n_req = 8'h00;
    logic port_in = 1'b1; // Pin kept as an input for the whole run
    logic port_read;
    logic bias_on;
    logic rf_wr = 1'b0;
    logic rf_rd = 1'b0;
    logic [6:0] rf_addr = 7'h00;
    logic [3:0] rf_wdata = 4'h0;
    logic [3:0] rf_rdata;
    logic pe_rd = 1'b0;
    logic [6:0] pe_addr = 7'h00;
    logic [15:0] dbuf;
    logic gate_open;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int open_len = 0;
    int open_base = 0;
    int i;

    always #20 sys_clk = ~sys_clk;

    hsync_frequency_counter #(.COUNT_WIDTH(6), .TICK_CYCLES(TICK), .GATE_CYCLES(GATE))
    i_hsync_frequency_counter (
        .sys_clk(sys_clk), .reset_n(reset_n), .clock_stop(clock_stop),
        .sync_count_input(sync_line), .shared_port_bit_in(port_in),
        .shared_port_bit_read(port_read), .input_bias_on(bias_on),
        .regfile_write_op(rf_wr), .regfile_read_op(rf_rd), .regfile_addr(rf_addr),
        .regfile_wdata(rf_wdata), .regfile_rdata(rf_rdata),
        .peripheral_read_op(pe_rd), .peripheral_addr(pe_addr),
        .transfer_buffer(dbuf), .gate_open(gate_open)
    );

    sync_source i_sync_source (
        .sys_clk(sys_clk), .reset_n(reset_n), .go(go), .n(n_req),
        .sync_line(sync_line), .busy(busy)
    );

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (gate_open === 1'b1) begin
            open_len <= open_len + 1;
        end
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic rf_write(input logic [6:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        rf_wr <= 1'b1;
        rf_addr <= a;
        rf_wdata <= d;
        @(posedge sys_clk);
        rf_wr <= 1'b0;
        #1;
    endtask : rf_write

    task automatic rf_read(input logic [6:0] a, output logic [3:0] d);
        @(posedge sys_clk);
        rf_rd <= 1'b1;
        rf_addr <= a;
        @(posedge sys_clk);
        rf_rd <= 1'b0;
        #1;
        d = rf_rdata;
    endtask : rf_read

    task automatic pe_read(input logic [6:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        pe_rd <= 1'b1;
        pe_addr <= a;
        @(posedge sys_clk);
        pe_rd <= 1'b0;
        #1;
        d = dbuf;
    endtask : pe_read

    task automatic send_pulses(input logic [7:0] k);
        int w;
        @(posedge sys_clk);
        go <= 1'b1;
        n_req <= k;
        @(posedge sys_clk);
        go <= 1'b0;
        #1;
        for (w = 0; w < 1200 && busy === 1'b1; w++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : send_pulses

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin : main
        logic [3:0] r;
        logic [15:0] p;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        rf_read(7'h11, r);
        check("mode after reset", {12'h000, r}, 16'h0000);
        pe_read(7'h04, p);
        check("count after reset", p, 16'h0000);
        check("bias closed", {15'h0000, bias_on}, 16'h0000);
        check("port bit as port", {15'h0000, port_read}, 16'h0001);
        // Open mode: 70 pulses wrap the six-bit count to 6
        rf_write(7'h11, 4'h1);
        check("bias open", {15'h0000, bias_on}, 16'h0001);
        check("gate open mode", {15'h0000, gate_open}, 16'h0001);
        check("port bit counting", {15'h0000, port_read}, 16'h0000);
        rf_read(7'h12, r);
        check("status open", {12'h000, r}, 16'h0008);
        send_pulses(8'd70);
        pe_read(7'h04, p);
        check("count wrapped", p, 16'h0006);
        // Closing the gate freezes the count
        rf_write(7'h11, 4'h0);
        check("port bit after close", {15'h0000, port_read}, 16'h0001);
        send_pulses(8'd5);
        pe_read(7'h04, p);
        check("count frozen", p, 16'h0006);
        check("gate closed", {15'h0000, gate_open}, 16'h0000);
        // Unmapped and read-only places leave read data as it was
        rf_write(7'h12, 4'hf);
        rf_read(7'h12, r);
        check("status write ignored", {12'h000, r}, 16'h0000);
        pe_read(7'h05, p);
        check("unmapped peripheral", p, 16'h0006);
        // Timed mode, upper data bits dropped
        open_base = open_len;
        rf_write(7'h11, 4'he);
        check("bias timed", {15'h0000, bias_on}, 16'h0001);
        rf_read(7'h12, r);
        check("status before tick", {12'h000, r}, 16'h0008);
        // The status read used two of the allowed tick cycles
        for (i = 0; i < TICK - 2 && gate_open !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("gate opened in time", {15'h0000, gate_open}, 16'h0001);
        rf_read(7'h11, r);
        check("mode readback", {12'h000, r}, 16'h0002);
        pe_read(7'h04, p);
        check("count cleared timed", p, 16'h0000);
        send_pulses(8'd3);
        // Software polls the flag with mask 1000B
        r = 4'h8;
        for (i = 0; i < 60 && (r & 4'h8) != 4'h0; i++) begin
            rf_read(7'h12, r);
        end
        check("status after gate", {12'h000, r}, 16'h0000);
        check("gate length", 16'(open_len - open_base), 16'(GATE));
        send_pulses(8'd4);
        pe_read(7'h04, p);
        check("timed count held", p, 16'h0003);
        // Clock stop forces closed mode and clears the count
        rf_write(7'h11, 4'h1);
        send_pulses(8'd2);
        @(posedge sys_clk);
        clock_stop <= 1'b1;
        repeat (2) @(posedge sys_clk);
        clock_stop <= 1'b0;
        rf_read(7'h11, r);
        check("mode after stop", {12'h000, r}, 16'h0000);
        pe_read(7'h04, p);
        check("count after stop", p, 16'h0000);
        // Spare mode code keeps the gate shut and the bias off
        rf_write(7'h11, 4'h3);
        check("spare mode shut", {14'h0000, bias_on, gate_open}, 16'h0000);
        rf_read(7'h11, r);
        check("spare readback", {12'h000, r}, 16'h0003);
        final_report();
    end
endmodule : tb_top
